// >>> logic/hdtx_port.sv
`timescale 1ns/1ps
module hdtx_port (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // configuration
   input wire logic i_telecom_bus_en,
   input wire logic i_hdlc_mode,
   input wire logic i_atm_uni_mode,
   input wire logic i_crc32_sel,
   // terminal equipment pins
   input wire logic i_message_send_cmd,
   input wire logic i_fcs_insert_cmd,
   input wire logic [7:0] i_frame_byte_in,
   output logic o_byte_ready,
   output logic o_overflow,
   output logic o_gfc_nibble_clock,
   // payload bit slot towards the framer
   input wire logic i_bit_ready,
   output logic o_tx_bit
);
   hdtx_fifo_if #(.W(hdtx_pkg::ENTRY_W)) cif ();

   hdtx_fifo #(
      .WIDTH(hdtx_pkg::ENTRY_W),
      .DEPTH(hdtx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .cif(cif.buf_side)
   );

   // one byte of reflected crc update, shared by both widths
   function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0] d,
                                           input logic w32);
      logic [31:0] v;
      logic fb;
      v = c;
      for (int i = 0; i < 8; i++) begin
         fb = v[0] ^ d[i];
         v = v >> 1;
         if (fb) begin
            v = v ^ (w32 ? hdtx_pkg::CRC32_POLY : hdtx_pkg::CRC16_POLY);
         end
      end
      return v;
   endfunction

   // ==========================================================
   // capture side
   logic cmd_en, fcs_edge;
   logic fcs_d_r, fcs_d_nxt, ovf_r, ovf_nxt, gfc_r, gfc_nxt;

   // pins mean commands only with the telecom bus off in hdlc mode
   always_comb begin
      cmd_en = ~i_telecom_bus_en & i_hdlc_mode;
      fcs_edge = i_fcs_insert_cmd & ~fcs_d_r;
      // the later cycles of the 2 or 4 cycle pulse are ignored
      cif.wr_valid = cmd_en & (i_message_send_cmd | fcs_edge);
      // a byte wins over a marker if both come together
      cif.wr_data = i_message_send_cmd ?
                    {1'b0, i_frame_byte_in} :
                    {1'b1, 8'h00};
      fcs_d_nxt = i_fcs_insert_cmd & cmd_en;
      ovf_nxt = ovf_r | (cif.wr_valid & ~cif.wr_ready);
      gfc_nxt = i_atm_uni_mode & i_fcs_insert_cmd;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fcs_d_r <= 1'b0;
         ovf_r <= 1'b0;
         gfc_r <= 1'b0;
      end else begin
         fcs_d_r <= fcs_d_nxt;
         ovf_r <= ovf_nxt;
         gfc_r <= gfc_nxt;
      end
   end

   assign o_byte_ready = cif.wr_ready;
   assign o_overflow = ovf_r;
   assign o_gfc_nibble_clock = gfc_r;

   // ==========================================================
   // serialiser: flags, data, trailer, zero insertion
   hdtx_pkg::hdtx_state_t state_r, state_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] cnt_r, cnt_nxt, ones_r, ones_nxt;
   logic [31:0] crc_r, crc_nxt, fcs_r, fcs_nxt;
   logic [1:0] fidx_r, fidx_nxt;
   logic w32_r, w32_nxt, bit_r, bit_nxt;
   logic [31:0] fcs_full;
   logic [1:0] fcs_last;
   logic stuff;

   always_comb begin
      state_nxt = state_r;
      sh_nxt = sh_r;
      cnt_nxt = cnt_r;
      ones_nxt = ones_r;
      crc_nxt = crc_r;
      fcs_nxt = fcs_r;
      fidx_nxt = fidx_r;
      w32_nxt = w32_r;
      bit_nxt = bit_r;
      cif.rd_ready = 1'b0;
      fcs_full = w32_r ? ~crc_r : (~crc_r & hdtx_pkg::CRC16_MASK);
      fcs_last = w32_r ? hdtx_pkg::FCS32_LAST : hdtx_pkg::FCS16_LAST;
      stuff = (ones_r == hdtx_pkg::STUFF_LIMIT);
      if (i_bit_ready) begin
         if (stuff) begin
            bit_nxt = 1'b0;
            ones_nxt = '0;
         end else begin
            bit_nxt = sh_r[0];
            // flags are never stuffed, so they do not count ones
            if (state_r == hdtx_pkg::ST_FLAG || !sh_r[0]) begin
               ones_nxt = '0;
            end else begin
               ones_nxt = ones_r + 1'b1;
            end
            sh_nxt = {1'b0, sh_r[7:1]};
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == hdtx_pkg::LAST_BIT) begin
               // default next octet is a flag: idle, close or underrun
               sh_nxt = hdtx_pkg::FLAG_OCTET;
               state_nxt = hdtx_pkg::ST_FLAG;
               if (state_r == hdtx_pkg::ST_FCS) begin
                  if (fidx_r != fcs_last) begin
                     state_nxt = hdtx_pkg::ST_FCS;
                     sh_nxt = fcs_r[7:0];
                     fcs_nxt = fcs_r >> 8;
                     fidx_nxt = fidx_r + 1'b1;
                  end
               end else if (cif.rd_valid) begin
                  cif.rd_ready = 1'b1;
                  if (!cif.rd_data[hdtx_pkg::MARK_BIT]) begin
                     state_nxt = hdtx_pkg::ST_DATA;
                     sh_nxt = cif.rd_data[7:0];
                     if (state_r == hdtx_pkg::ST_FLAG) begin
                        // width is fixed for the whole frame
                        w32_nxt = i_crc32_sel;
                        crc_nxt = crc_byte(i_crc32_sel ?
                                           hdtx_pkg::CRC32_INIT :
                                           hdtx_pkg::CRC16_INIT,
                                           cif.rd_data[7:0],
                                           i_crc32_sel);
                     end else begin
                        crc_nxt = crc_byte(crc_r, cif.rd_data[7:0],
                                           w32_r);
                     end
                  end else if (state_r == hdtx_pkg::ST_DATA) begin
                     state_nxt = hdtx_pkg::ST_FCS;
                     sh_nxt = fcs_full[7:0];
                     fcs_nxt = fcs_full >> 8;
                     fidx_nxt = '0;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= hdtx_pkg::ST_FLAG;
         sh_r <= hdtx_pkg::FLAG_OCTET;
         cnt_r <= '0;
         ones_r <= '0;
         crc_r <= '0;
         fcs_r <= '0;
         fidx_r <= '0;
         w32_r <= 1'b0;
         bit_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sh_r <= sh_nxt;
         cnt_r <= cnt_nxt;
         ones_r <= ones_nxt;
         crc_r <= crc_nxt;
         fcs_r <= fcs_nxt;
         fidx_r <= fidx_nxt;
         w32_r <= w32_nxt;
         bit_r <= bit_nxt;
      end
   end

   assign o_tx_bit = bit_r;

   // ==========================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   AST_CAPTURE_BYTE: assert property (
      (cmd_en && i_message_send_cmd) |->
      (cif.wr_valid && cif.wr_data == {1'b0, i_frame_byte_in}))
      else $error("byte not offered while send command high");
   AST_IDLE_IGNORES_BUS: assert property (
      (!i_message_send_cmd && !fcs_edge) |-> !cif.wr_valid)
      else $error("bus sampled while send command low");
   AST_FLAG_BITS: assert property (
      (state_r == hdtx_pkg::ST_FLAG && i_bit_ready && !stuff) |=>
      (o_tx_bit == hdtx_pkg::FLAG_OCTET[$past(cnt_r)]))
      else $error("idle bit differs from flag pattern");
   AST_ZERO_INSERT: assert property (
      (ones_r == hdtx_pkg::STUFF_LIMIT && i_bit_ready) |=>
      (!o_tx_bit && ones_r == 3'h0))
      else $error("no zero after five ones");
   AST_FCS_MARKER: assert property (
      (cmd_en && fcs_edge && !i_message_send_cmd) |->
      (cif.wr_valid && cif.wr_data[hdtx_pkg::MARK_BIT]))
      else $error("trailer command not queued");
   AST_FCS_ENDS_IN_FLAG: assert property (
      (state_r == hdtx_pkg::ST_FCS && fidx_r == fcs_last &&
       cnt_r == hdtx_pkg::LAST_BIT && i_bit_ready && !stuff) |=>
      (state_r == hdtx_pkg::ST_FLAG && sh_r == hdtx_pkg::FLAG_OCTET))
      else $error("trailer not followed by closing flag");
   AST_PINS_GATED: assert property (
      (i_telecom_bus_en || !i_hdlc_mode) |-> !cif.wr_valid)
      else $error("commands acted on outside controller mode");
   AST_GFC_ROLE: assert property (
      !i_atm_uni_mode |=> !o_gfc_nibble_clock)
      else $error("nibble clock driven outside atm mode");

   COV_DATA_FRAME: cover property (state_r == hdtx_pkg::ST_DATA ##1
                                   state_r == hdtx_pkg::ST_FCS);
   COV_FCS32: cover property (state_r == hdtx_pkg::ST_FCS && w32_r &&
                              fidx_r == hdtx_pkg::FCS32_LAST);
   COV_STUFF: cover property (stuff && i_bit_ready);
   COV_OVERFLOW: cover property (cif.wr_valid && !cif.wr_ready);
endmodule

// >>> pkg/hdtx_pkg.sv
package hdtx_pkg;
   // ==========================================================
   // byte path and fifo shape
   localparam int BYTE_W = 8;
   localparam int ENTRY_W = 9;
   localparam int MARK_BIT = 8;
   localparam int FIFO_DEPTH = 16;

   // ==========================================================
   // framing constants
   localparam logic [7:0] FLAG_OCTET = 8'h7E;
   localparam logic [2:0] STUFF_LIMIT = 3'h5;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] FCS16_LAST = 2'h1;
   localparam logic [1:0] FCS32_LAST = 2'h3;

   // ==========================================================
   // frame check sequence, reflected, sent lsb first
   localparam logic [31:0] CRC16_POLY = 32'h0000_8408;
   localparam logic [31:0] CRC32_POLY = 32'hEDB8_8320;
   localparam logic [31:0] CRC16_INIT = 32'h0000_FFFF;
   localparam logic [31:0] CRC32_INIT = 32'hFFFF_FFFF;
   localparam logic [31:0] CRC16_MASK = 32'h0000_FFFF;

   // ==========================================================
   // transmitter states
   typedef enum logic [1:0] {ST_FLAG, ST_DATA, ST_FCS} hdtx_state_t;
endpackage

// >>> pkg/hdtx_fifo_if.sv
`timescale 1ns/1ps
interface hdtx_fifo_if #(parameter int W = 9);
   logic wr_valid;
   logic wr_ready;
   logic [W-1:0] wr_data;
   logic rd_valid;
   logic rd_ready;
   logic [W-1:0] rd_data;

   // the framer side fills and drains, the buffer answers
   modport src (output wr_valid, output wr_data, output rd_ready,
                input wr_ready, input rd_valid, input rd_data);
   modport buf_side (input wr_valid, input wr_data, input rd_ready,
                     output wr_ready, output rd_valid, output rd_data);
endinterface

// >>> logic/hdtx_fifo.sv
`timescale 1ns/1ps
module hdtx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // both sides of the buffer
   hdtx_fifo_if.buf_side cif
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic full_r, full_nxt, empty_r, empty_nxt;
   logic rdy_r, rdy_nxt;
   logic push, pop;

   // ==========================================================
   // pointers and flags; full and empty are flops so both readies
   // reach the ports without a combinational path
   always_comb begin
      push = cif.wr_valid & ~full_r;
      pop = cif.rd_ready & ~empty_r;
      wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
      rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
      cnt_nxt = cnt_r;
      if (push && !pop) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_nxt = cnt_r - 1'b1;
      end
      full_nxt = (cnt_nxt == FULL_CNT);
      empty_nxt = (cnt_nxt == '0);
      // ready is its own flop so the top port needs no inverter
      rdy_nxt = ~full_nxt;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r <= '0;
         full_r <= 1'b0;
         empty_r <= 1'b1;
         rdy_r <= 1'b1;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         cnt_r <= cnt_nxt;
         full_r <= full_nxt;
         empty_r <= empty_nxt;
         rdy_r <= rdy_nxt;
      end
   end

   // storage has no reset; empty_r guards stale words
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= cif.wr_data;
      end
   end

   assign cif.wr_ready = rdy_r;
   assign cif.rd_valid = ~empty_r;
   assign cif.rd_data = mem[rd_ptr_r];

   // ==========================================================
   // buffer checks
   AST_FIFO_FULL_REFUSES: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (cnt_r == FULL_CNT) |-> !cif.wr_ready)
      else $error("fifo full but still ready");
   AST_FIFO_COUNT: assert property (
      @(posedge i_clk) disable iff (!i_rst_b)
      (push && !pop) |=> (cnt_r == $past(cnt_r) + 1'b1))
      else $error("fifo count did not grow on push");
   COV_FIFO_FULL: cover property (
      @(posedge i_clk) disable iff (!i_rst_b) full_r);
endmodule

// >>> sim/hdtx_term.sv
`timescale 1ns/1ps
// ==========================================================
// terminal equipment: feeds message bytes and trailer commands
module hdtx_term (
   // clock
   input wire logic i_clk,
   // command pins and byte bus
   output logic o_message_send_cmd,
   output logic o_fcs_insert_cmd,
   output logic [7:0] o_frame_byte_in
);
   // pins idle low, bus holds a neutral value until used
   initial begin
      o_message_send_cmd = 1'b0;
      o_fcs_insert_cmd = 1'b0;
      o_frame_byte_in = 8'h00;
   end

   // one frame: bytes back to back, then the trailer command
   task automatic send_frame(input logic [7:0] d[$], input int fcs_n);
      int i;
      for (i = 0; i < d.size(); i++) begin
         @(posedge i_clk);
         o_message_send_cmd <= 1'b1;
         o_frame_byte_in <= d[i];
      end
      @(posedge i_clk);
      // released bus shows the inverse so stale data never looks valid
      o_message_send_cmd <= 1'b0;
      o_frame_byte_in <= ~d[d.size()-1];
      o_fcs_insert_cmd <= (fcs_n > 0);
      for (i = 1; i < fcs_n; i++) begin
         @(posedge i_clk); // two or four periods
      end
      @(posedge i_clk);
      o_fcs_insert_cmd <= 1'b0;
   endtask

   // plain level on the trailer pin, used as nibble clock
   task automatic pin(input logic v);
      @(posedge i_clk);
      o_fcs_insert_cmd <= v;
   endtask

   // outside controller mode both commands go to ground
   task automatic idle_pins();
      @(posedge i_clk);
      o_message_send_cmd <= 1'b0;
      o_fcs_insert_cmd <= 1'b0;
   endtask
endmodule

// >>> sim/hdtx_port_tb.sv
`timescale 1ns/1ps
module hdtx_port_tb;
   typedef logic [7:0] hdtx_bq_t[$];
   logic clk, rst_b, telecom_en, hdlc_mode, atm_mode, crc32_sel;
   logic bit_ready, stall, prev_rdy, send, fcs, byte_ready, overflow;
   logic gfc, tx_bit, synced;
   logic [7:0] byte_in;
   logic [31:0] cyc;
   int miscompares = 0;
   int samples_checked = 0;
   int ones = 0;
   int flags_seen = 0;
   int frames_got = 0;
   logic acc[$];
   logic [7:0] exp_q[$];
   int exp_len[$];

   // ==========================================================
   // clock, bit slots and the parts under test
   initial clk = 1'b0;
   always #50 clk = ~clk;

   hdtx_term term (.i_clk(clk), .o_message_send_cmd(send),
      .o_fcs_insert_cmd(fcs), .o_frame_byte_in(byte_in));

   hdtx_port uut (.i_clk(clk), .i_rst_b(rst_b),
      .i_telecom_bus_en(telecom_en), .i_hdlc_mode(hdlc_mode),
      .i_atm_uni_mode(atm_mode), .i_crc32_sel(crc32_sel),
      .i_message_send_cmd(send), .i_fcs_insert_cmd(fcs),
      .i_frame_byte_in(byte_in), .o_byte_ready(byte_ready),
      .o_overflow(overflow), .o_gfc_nibble_clock(gfc),
      .i_bit_ready(bit_ready), .o_tx_bit(tx_bit));

   // framer takes three slots of four, so the serialiser must wait
   always @(posedge clk) begin
      cyc <= cyc + 32'h0000_0001;
      bit_ready <= !stall && (cyc[1:0] != 2'h3);
      prev_rdy <= bit_ready;
      if (prev_rdy && rst_b) take(tx_bit);
   end

   // ==========================================================
   // comparison and verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] ev);
      samples_checked++;
      if (seen !== ev) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, ev);
      end
   endtask

   task automatic results();
      if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================================
   // line decoder: drops stuffed zeros, splits on flags
   task automatic take(input logic b);
      if (!b && ones == 5) begin
         ones = 0;
      end else if (!b && ones == 6) begin
         ones = 0;
         flags_seen++;
         if (synced && acc.size() > 7) frame_end();
         synced = 1'b1;
         acc.delete();
      end else begin
         acc.push_back(b);
         ones = b ? ones + 1 : 0;
      end
   endtask

   task automatic frame_end();
      int n, i, k;
      logic [7:0] v, e;
      n = acc.size() - 7;
      frames_got++;
      check(32'(n % 8), 32'h0000_0000);
      check(32'(n / 8), exp_len.size() != 0 ? 32'(exp_len.pop_front())
            : 32'h0000_0000);
      for (i = 0; i + 8 <= n; i += 8) begin
         for (k = 0; k < 8; k++) v[k] = acc[i + k];
         e = (exp_q.size() != 0) ? exp_q.pop_front() : ~v;
         check(32'(v), 32'(e));
      end
   endtask

   // ==========================================================
   // reference check sequence, reflected and complemented
   function automatic logic [31:0] fcs_of(input hdtx_bq_t d, input logic w);
      logic [31:0] c;
      int i, k;
      c = w ? hdtx_pkg::CRC32_INIT : hdtx_pkg::CRC16_INIT;
      for (i = 0; i < d.size(); i++) begin
         c = c ^ {24'h00_0000, d[i]};
         for (k = 0; k < 8; k++)
            c = c[0] ? (c >> 1) ^ (w ? hdtx_pkg::CRC32_POLY
                : hdtx_pkg::CRC16_POLY) : (c >> 1);
      end
      return ~c;
   endfunction

   task automatic frame(input hdtx_bq_t d, input logic w);
      logic [31:0] f;
      int i;
      f = fcs_of(d, w);
      for (i = 0; i < d.size(); i++) exp_q.push_back(d[i]);
      for (i = 0; i < (w ? 4 : 2); i++) exp_q.push_back(f[8*i +: 8]);
      exp_len.push_back(d.size() + (w ? 4 : 2));
      @(posedge clk);
      crc32_sel <= w;
      term.send_frame(d, w ? 4 : 2);
      // width is taken when the first byte leaves the buffer, which
      // can be a whole flag later, so hold the selection that long
      repeat (6) @(posedge clk);
   endtask

   // bounded wait until every expected frame came out
   task automatic drain();
      int n;
      n = 0;
      while (exp_len.size() != 0 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      check(32'(exp_len.size()), 32'h0000_0000);
      repeat (24) @(posedge clk);
   endtask

   // ==========================================================
   // watchdog at 20000 cycles, far above the several hundred cycles the tests need
   initial begin
      #2000000;
      miscompares++;
      results();
   end

   initial begin
      hdtx_bq_t big;
      int f0, i;
      rst_b = 1'b0; telecom_en = 1'b0; hdlc_mode = 1'b1; atm_mode = 1'b0;
      crc32_sel = 1'b0; stall = 1'b0; cyc = 32'h0000_0000;
      bit_ready = 1'b0; prev_rdy = 1'b0; synced = 1'b0;
      repeat (2) @(posedge clk);
      #10;
      check(32'(byte_ready), 32'h0000_0001);
      check(32'(overflow), 32'h0000_0000);
      check(32'(gfc), 32'h0000_0000);
      @(posedge clk);
      rst_b <= 1'b1;
      // idle line carries only flags while the bus holds its neutral value
      f0 = flags_seen;
      repeat (80) @(posedge clk);
      check(32'(flags_seen - f0 >= 6), 32'h0000_0001);
      // back-to-back frames, stuffing-heavy data, both check widths
      frame('{8'hFF, 8'h7E, 8'h00, 8'hF8, 8'h1F}, 1'b0);
      frame('{8'h7E, 8'h01, 8'hFE}, 1'b1);
      drain();
      // commands ignored while the telecom bus owns the pins, then with hdlc mode off
      f0 = frames_got;
      @(posedge clk) telecom_en <= 1'b1;
      term.send_frame('{8'h55, 8'hAA}, 2);
      @(posedge clk) telecom_en <= 1'b0;
      hdlc_mode <= 1'b0;
      term.send_frame('{8'h33}, 2);
      repeat (150) @(posedge clk);
      check(32'(frames_got - f0), 32'h0000_0000);
      // trailer pin as nibble clock only in atm mode
      telecom_en <= 1'b1;
      hdlc_mode <= 1'b1;
      atm_mode <= 1'b1;
      for (i = 0; i < 4; i++) begin
         term.pin(i[0]);
         @(posedge clk);
         #1 check(32'(gfc), 32'(i[0]));
      end
      @(posedge clk) atm_mode <= 1'b0;
      term.pin(1'b1);
      repeat (2) @(posedge clk);
      #1 check(32'(gfc), 32'h0000_0000);
      term.pin(1'b0);
      // fill the buffer with the framer stalled until it refuses
      @(posedge clk) telecom_en <= 1'b0;
      stall <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 0; i < 17; i++) big.push_back(8'(8'h10 + i));
      for (i = 0; i < 16; i++) exp_q.push_back(big[i]);
      exp_len.push_back(16);
      term.send_frame(big, 0);
      #1 check(32'(byte_ready), 32'h0000_0000);
      check(32'(overflow), 32'h0000_0001);
      @(posedge clk) stall <= 1'b0;
      drain();
      check(32'(byte_ready), 32'h0000_0001);
      term.idle_pins();
      results();
   end
endmodule
